/* File: verilog/lmr_refresh.sv */
// Purpose: Row refresh sequencer for a 20 x 8 dot LED matrix driver
// Assumes: Register master per plain strobe port, read data next cycle
// Notes:   Row and column outputs lag the frame counter by one clock
//
// Contract
// - 160 dots as 20x8, rows lit in turn
// - Frame lasts exactly 512 display clocks
// - Each row owns a 64-cycle slot
// - Last four slot cycles blank, 60 lit max
// - At most 20 LEDs lit, one per column
// - Peak from D5:D4, duty from D3:D0
// - Peak and duty act independently
// - Display clock from internal or external oscillator
// - Prescaler bit divides external oscillator by eight
//
// The address map and strobed register access were chosen for this implementation.
`include "lmr_cfg.svh"
module lmr_refresh #(
  parameter int ROWS        = `LMR_ROWS,
  parameter int COLS        = `LMR_COLS,
  parameter int INT_OSC_DIV = `LMR_CLK_HZ / `LMR_INT_OSC_HZ
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`LMR_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic                   osc_ext_in,
  output logic      [ROWS-1:0]        row_on,
  output logic      [COLS-1:0]        col_on,
  output logic      [1:0]             peak_sel,
  output logic                        frame_start
);

  localparam int FR_W = $clog2(`LMR_FRAME_CYC);
  localparam int PH_W = $clog2(`LMR_SLOT_CYC);
  localparam logic [FR_W-1:0] FR_LAST = FR_W'(`LMR_FRAME_CYC - 1);
  localparam logic [PH_W-1:0] LIT_MAX = PH_W'(`LMR_LIT_MAX);

  // ************************************************************
  // Register file
  // ************************************************************
  logic [6:0]      ctrl0_r, ctrl0_nxt;
  logic [1:0]      ctrl1_r, ctrl1_nxt;
  logic            ext_sel_r, ext_sel_nxt;
  logic [COLS-1:0] dots_r [ROWS];
  logic [COLS-1:0] dots_nxt [ROWS];
  logic [31:0]     rdata_r, rdata_nxt;
  logic [15:0]     frames_r, frames_nxt;
  logic [FR_W-1:0] cnt_r, cnt_nxt;
  logic            dot_hit;
  logic [2:0]      dot_row;

  // Address decode of dot page: one word per row
  assign dot_hit = (reg_addr[`LMR_ADDR_W-1:`LMR_DOT_PAGE_LSB]
                    == `LMR_DOT_PAGE);
  assign dot_row = reg_addr[`LMR_DOT_PAGE_LSB-1:`LMR_DOT_ROW_LSB];

  // Writes store, reads answer next cycle, unmapped reads give zero
  always_comb begin
    ctrl0_nxt   = ctrl0_r;
    ctrl1_nxt   = ctrl1_r;
    ext_sel_nxt = ext_sel_r;
    dots_nxt    = dots_r;
    rdata_nxt   = 32'h0000_0000;
    if (reg_wr) begin
      if (dot_hit) begin
        dots_nxt[dot_row] = reg_wdata[COLS-1:0];
      end else begin
        unique case (reg_addr)
          `LMR_OFS_CTRL0: ctrl0_nxt   = reg_wdata[6:0];
          `LMR_OFS_CTRL1: ctrl1_nxt   = reg_wdata[1:0];
          `LMR_OFS_CFG:   ext_sel_nxt = reg_wdata[`LMR_CFG_EXT_SEL];
          default: ;
        endcase
      end
    end
    if (reg_rd) begin
      if (dot_hit) begin
        rdata_nxt[COLS-1:0] = dots_r[dot_row];
      end else begin
        unique case (reg_addr)
          `LMR_OFS_CTRL0: rdata_nxt[6:0] = ctrl0_r;
          `LMR_OFS_CTRL1: rdata_nxt[1:0] = ctrl1_r;
          `LMR_OFS_CFG:   rdata_nxt[0]   = ext_sel_r;
          `LMR_OFS_STAT:  rdata_nxt      = {frames_r, 7'h00, cnt_r};
          default: ;
        endcase
      end
    end
  end

  // Register stage of the register file
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_r   <= `LMR_C0_RST;
      ctrl1_r   <= `LMR_C1_RST;
      ext_sel_r <= `LMR_CFG_RST;
      rdata_r   <= 32'h0000_0000;
      for (int i = 0; i < ROWS; i++) begin
        dots_r[i] <= '0;
      end
    end else begin
      ctrl0_r   <= ctrl0_nxt;
      ctrl1_r   <= ctrl1_nxt;
      ext_sel_r <= ext_sel_nxt;
      rdata_r   <= rdata_nxt;
      dots_r    <= dots_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ************************************************************
  // Display clock
  // ************************************************************
  lmr_osc_if osc ();

  // Clearing the awake bit stops the oscillator and blanks all
  assign osc.src      = ext_sel_r ? lmr_pkg::LMR_SRC_EXT
                                  : lmr_pkg::LMR_SRC_INT;
  assign osc.prescale = ctrl1_r[`LMR_C1_PRESCALE];
  assign osc.run      = ctrl0_r[`LMR_C0_AWAKE];

  lmr_osc_gen #(
    .INT_OSC_DIV (INT_OSC_DIV)
  ) u_osc (
    .clk        (clk),
    .rst_n      (rst_n),
    .osc_ext_in (osc_ext_in),
    .osc        (osc.gen)
  );

  // ************************************************************
  // Refresh sequencer
  // ************************************************************
  lmr_pkg::lmr_row_t   row;
  lmr_pkg::lmr_phase_t phase;
  logic [5:0]          on_time;
  logic                lit;
  logic [ROWS-1:0]     row_on_r, row_on_nxt;
  logic [COLS-1:0]     col_on_r, col_on_nxt;
  logic [1:0]          peak_r, peak_nxt;
  logic                fstart_r, fstart_nxt;

  // On-time in display clocks per duty code
  function automatic logic [5:0] lmr_on_cycles(input lmr_pkg::lmr_duty_t d);
    logic [5:0] c;
    unique case (d)
      4'h0: c = 6'h00;
      4'h1: c = 6'h01;
      4'h2: c = 6'h02;
      4'h3: c = 6'h03;
      4'h4: c = 6'h04;
      4'h5: c = 6'h05;
      4'h6: c = 6'h07;
      4'h7: c = 6'h09;
      4'h8: c = 6'h0B;
      4'h9: c = 6'h0E;
      4'hA: c = 6'h12;
      4'hB: c = 6'h16;
      4'hC: c = 6'h1C;
      4'hD: c = 6'h24;
      4'hE: c = 6'h30;
      4'hF: c = 6'h3C;
    endcase
    return c;
  endfunction

  // Frame counter splits into row slot and phase within it
  assign row   = cnt_r[FR_W-1:PH_W];
  assign phase = cnt_r[PH_W-1:0];
  assign on_time = lmr_on_cycles(
    ctrl0_r[`LMR_C0_DUTY_HI:`LMR_C0_DUTY_LO]);
  // Duty only gates time, peak code travels apart: product of both
  assign lit = osc.run && (phase < on_time) && (phase < LIT_MAX);

  always_comb begin
    cnt_nxt    = cnt_r;
    frames_nxt = frames_r;
    if (osc.tick) begin
      // No idle state between the last slot and the next frame
      cnt_nxt = (cnt_r == FR_LAST) ? '0 : cnt_r + 1'b1;
      if (cnt_r == FR_LAST) begin
        frames_nxt = frames_r + 1'b1;
      end
    end
    // Single row sink per slot caps the lit dots at one per column
    row_on_nxt = lit ? (ROWS'(1) << row) : '0;
    col_on_nxt = lit ? dots_r[row] : '0;
    peak_nxt   = ctrl0_r[`LMR_C0_PEAK_HI:`LMR_C0_PEAK_LO];
    fstart_nxt = osc.tick && (cnt_r == FR_LAST);
  end

  // Register stage of the sequencer and its outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r    <= '0;
      frames_r <= 16'h0000;
      row_on_r <= '0;
      col_on_r <= '0;
      peak_r   <= 2'h0;
      fstart_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      frames_r <= frames_nxt;
      row_on_r <= row_on_nxt;
      col_on_r <= col_on_nxt;
      peak_r   <= peak_nxt;
      fstart_r <= fstart_nxt;
    end
  end

  assign row_on      = row_on_r;
  assign col_on      = col_on_r;
  assign peak_sel    = peak_r;
  assign frame_start = fstart_r;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_row_single: assert property (
    $onehot0(row_on_r))
    else $error("more than one row driver on");
  a_frame_wrap: assert property (
    osc.tick && cnt_r == FR_LAST |=> cnt_r == '0 ##0 fstart_r)
    else $error("frame did not wrap after 512 cycles");
  a_row_slot: assert property (
    row_on_r != '0 |-> row_on_r == (ROWS'(1) << $past(cnt_r[FR_W-1:PH_W])))
    else $error("lit row does not match its slot");
  a_blank_gap: assert property (
    $past(cnt_r[PH_W-1:0]) >= LIT_MAX |-> row_on_r == '0 && col_on_r == '0)
    else $error("output lit during blank cycles");
  a_col_one_row: assert property (
    col_on_r != '0 |-> $onehot(row_on_r))
    else $error("columns lit without exactly one row");
  a_duty_gate: assert property (
    row_on_r != '0 |-> $past(phase) < $past(on_time))
    else $error("row lit past its on-time");
  a_peak_indep: assert property (
    row_on_r != '0 |-> col_on_r == $past(dots_r[row])
                       && peak_r == $past(ctrl0_r[5:4]))
    else $error("peak and duty interfere");
  a_no_gap: assert property (
    osc.tick && cnt_r == FR_LAST && ctrl0_r[3:0] == 4'hF && osc.run
    |=> row_on_r == '0 ##1 row_on_r == ROWS'(1))
    else $error("idle gap after last row slot");
  a_read_answer: assert property (
    reg_rd && reg_addr == `LMR_OFS_CTRL0 |=> reg_rdata == {25'h0, $past(ctrl0_r)})
    else $error("control word read back wrong");
  a_read_idle: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");

  c_full_frame: cover property (fstart_r && frames_r == 16'h0002);
  c_last_row:   cover property (row_on_r[ROWS-1] && col_on_r != '0);
  c_dim_duty:   cover property (row_on_r != '0 && ctrl0_r[3:0] == 4'h1);
  c_sleep:      cover property (!osc.run ##1 osc.run);

endmodule

/* File: verilog/lmr_cfg.svh */
// Purpose: Constants of the LED matrix row refresh sequencer
// Assumes: 100 MHz system clock, 32-bit register port
// Notes:   Offsets are byte addresses on the register port
`ifndef LMR_CFG_SVH
`define LMR_CFG_SVH

// ************************************************************
// Register map
// ************************************************************
`define LMR_ADDR_W        8
`define LMR_OFS_CTRL0     8'h00
`define LMR_OFS_CTRL1     8'h04
`define LMR_OFS_CFG       8'h08
`define LMR_OFS_STAT      8'h0C
`define LMR_DOT_PAGE      3'h2
`define LMR_DOT_PAGE_LSB  5
`define LMR_DOT_ROW_LSB   2

// ************************************************************
// Field positions
// ************************************************************
`define LMR_C0_AWAKE      6
`define LMR_C0_PEAK_HI    5
`define LMR_C0_PEAK_LO    4
`define LMR_C0_DUTY_HI    3
`define LMR_C0_DUTY_LO    0
`define LMR_C1_SERIAL     0
`define LMR_C1_PRESCALE   1
`define LMR_CFG_EXT_SEL   0

// ************************************************************
// Reset values
// ************************************************************
`define LMR_C0_RST        7'h00
`define LMR_C1_RST        2'h0
`define LMR_CFG_RST       1'h0

// ************************************************************
// Timing
// ************************************************************
`define LMR_CLK_HZ        100000000
`define LMR_INT_OSC_HZ    390625
`define LMR_FRAME_CYC     512
`define LMR_ROWS          8
`define LMR_COLS          20
`define LMR_SLOT_CYC      64
`define LMR_BLANK_CYC     4
`define LMR_LIT_MAX       60
`define LMR_PRESCALE      8

`endif

/* File: verilog/lmr_pkg.sv */
// Purpose: Types of the LED matrix row refresh sequencer
// Assumes: Constants come from lmr_cfg.svh
// Notes:   Nothing here is imported; users write lmr_pkg::name
package lmr_pkg;

  // Oscillator source of the display clock
  typedef enum logic {LMR_SRC_INT, LMR_SRC_EXT} lmr_src_e;

  typedef logic [3:0] lmr_duty_t;
  typedef logic [1:0] lmr_peak_t;
  typedef logic [5:0] lmr_phase_t;
  typedef logic [2:0] lmr_row_t;

endpackage

/* File: verilog/lmr_osc_if.sv */
// Purpose: Link between refresh core and display clock generator
// Assumes: One clock domain on both sides
// Notes:   tick is a one-cycle pulse per display clock period
interface lmr_osc_if;
  lmr_pkg::lmr_src_e src;
  logic              prescale;
  logic              run;
  logic              tick;

  modport ctl (output src, output prescale, output run, input tick);
  modport gen (input src, input prescale, input run, output tick);
endinterface

/* File: verilog/lmr_osc_gen.sv */
// Purpose: Display clock tick from internal divider or external pin
// Assumes: External oscillator well below a quarter of clk
// Notes:   Prescaler divides only the external source by eight
`include "lmr_cfg.svh"
module lmr_osc_gen #(
  parameter int INT_OSC_DIV = `LMR_CLK_HZ / `LMR_INT_OSC_HZ
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic osc_ext_in,
  lmr_osc_if.gen    osc
);

  localparam int DIV_W = $clog2(INT_OSC_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_OSC_DIV - 1);
  localparam logic [2:0] PRE_LAST = 3'(`LMR_PRESCALE - 1);

  logic [2:0]       sync_r, sync_nxt;
  logic             lvl_r, lvl_nxt;
  logic [DIV_W-1:0] div_r, div_nxt;
  logic [2:0]       pre_r, pre_nxt;
  logic             ext_edge;
  logic             int_wrap;

  // ************************************************************
  // Source filtering and division
  // ************************************************************
  // Pin level counts only once stages two and three agree
  always_comb begin
    sync_nxt = {sync_r[1:0], osc_ext_in};
    lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
    ext_edge = lvl_nxt & ~lvl_r;
    int_wrap = (div_r == DIV_LAST);
    div_nxt  = int_wrap ? '0 : div_r + 1'b1;
    pre_nxt  = pre_r;
    osc.tick = 1'b0;
    if (!osc.run) begin
      // Stopped oscillator restarts a clean prescaler phase
      pre_nxt = '0;
    end else if (osc.src == lmr_pkg::LMR_SRC_INT) begin
      osc.tick = int_wrap;
    end else if (ext_edge) begin
      if (!osc.prescale) begin
        osc.tick = 1'b1;
      end else begin
        pre_nxt  = (pre_r == PRE_LAST) ? '0 : pre_r + 1'b1;
        osc.tick = (pre_r == PRE_LAST);
      end
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= '0;
      lvl_r  <= 1'b0;
      div_r  <= '0;
      pre_r  <= '0;
    end else begin
      sync_r <= sync_nxt;
      lvl_r  <= lvl_nxt;
      div_r  <= div_nxt;
      pre_r  <= pre_nxt;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_pre_div_eight: assert property (@(posedge clk) disable iff (!rst_n)
    osc.tick && osc.run && osc.src == lmr_pkg::LMR_SRC_EXT && osc.prescale
    |-> ext_edge && pre_r == PRE_LAST)
    else $error("prescaled tick not on eighth edge");
  a_src_select: assert property (@(posedge clk) disable iff (!rst_n)
    osc.tick |-> (osc.src == lmr_pkg::LMR_SRC_EXT ? ext_edge : int_wrap))
    else $error("tick from unselected source");
  c_ext_prescaled: cover property (@(posedge clk) disable iff (!rst_n)
    osc.tick && osc.prescale && osc.src == lmr_pkg::LMR_SRC_EXT);

endmodule

/* File: bench/lmr_led_array.sv */
// Purpose: LED array model behind the row sinks and column sources
// Assumes: Oscillator rates stay inside the limits for the prescale mode
// Notes:   Counts its own faults; the bench adds them to its verdict
module lmr_led_array (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  row_on,
  input  wire logic [19:0] col_on,
  input  wire logic        fast,
  output logic             osc_ext,
  output int               faults
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // External oscillator: 1 MHz direct, 8 MHz for the prescaler
  // ************************************************************
  int fault_cnt = 0;

  assign faults = fault_cnt;

  // Free running, as a real oscillator module would be
  initial begin
    osc_ext = 1'b0;
    forever begin
      #((fast === 1'b1) ? 62.5 : 500.0);
      osc_ext = ~osc_ext;
    end
  end

  // ************************************************************
  // Pin checks
  // ************************************************************
  // Two sinks at once would overload the column sources
  // Sampled mid-cycle, away from the edge that moves the pins
  always @(negedge clk) begin
    if (rst_n === 1'b1) begin
      if ($countones(row_on) > 1 ||
          (row_on === 8'h00 && col_on !== 20'h00000)) begin
        fault_cnt++;
        $display("Error at %0t: rows %h cols %h", $time, row_on, col_on);
      end
    end
  end
endmodule

/* File: bench/test_led_matrix_row_refresh.sv */
// Purpose: Self-checking bench of the row refresh sequencer
// Assumes: Internal divider shortened to 4 clocks per display tick
// Notes:   Lit lengths are counted in clk cycles at the row pins
module test_led_matrix_row_refresh;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DIV = 4;

  logic        clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        osc_ext_in;
  logic [7:0]  row_on;
  logic [19:0] col_on;
  logic [1:0]  peak_sel;
  logic        frame_start;
  logic        fast;
  logic [31:0] d;
  logic [31:0] d2;
  logic [19:0] dots [8];
  int          errors;
  int          tests_run;
  int          faults;
  int          cyc;
  int          n;
  int          r;
  int          r0;
  int          on_t [16] = '{0, 1, 2, 3, 4, 5, 7, 9, 11, 14, 18, 22, 28,
                             36, 48, 60};

  lmr_refresh #(.INT_OSC_DIV(DIV)) i_dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_ext_in(osc_ext_in), .row_on(row_on),
    .col_on(col_on), .peak_sel(peak_sel), .frame_start(frame_start));

  lmr_led_array i_leds (
    .clk(clk), .rst_n(rst_n), .row_on(row_on), .col_on(col_on),
    .fast(fast), .osc_ext(osc_ext_in), .faults(faults));

  // ************************************************************
  // Clock, watchdog and verdict
  // ************************************************************
  always #5 clk = ~clk;

  // Whole run is about 25000 cycles; well past that means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (errors + faults == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sync stages add a clk or two of jitter on the external source
  task automatic chk_near(input int got, input int exp);
    tests_run++;
    if (got - exp > 3 || exp - got > 3) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Next whole lit episode: its length, its row, columns checked
  task automatic lit_len(output int len, output int row);
    logic [7:0] p;
    len = 0;
    row = 0;
    do begin
      p = row_on;
      @(posedge clk);
    end while (!(row_on !== 8'h00 && p === 8'h00));
    for (int i = 0; i < 8; i++) if (row_on[i] === 1'b1) row = i;
    while (row_on !== 8'h00) begin
      len++;
      if (col_on !== dots[row]) chk(col_on, dots[row]);
      @(posedge clk);
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fast = 1'b0;
    errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, read-only status and an unmapped hole
    wr(8'h0C, 32'hFFFFFFFF);
    foreach (on_t[i]) if (i < 4) begin
      rd(8'(i * 4), d);
      chk(d, 32'h0);
    end
    rd(8'h30, d);
    chk(d, 32'h0);
    // Distinct dot rows so a wrong row shows on the columns
    for (int i = 0; i < 8; i++) begin
      dots[i] = 20'h13579 + 20'(i) * 20'h0F1E3;
      wr(8'(8'h40 + i * 4), {12'h000, dots[i]});
    end
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h40 + i * 4), d);
      chk(d, {12'h000, dots[i]});
    end
    // Every duty code, peak code riding along to show independence
    for (int c = 0; c < 16; c++) begin
      wr(8'h00, 32'h40 | 32'((c & 3) << 4) | 32'(c));
      if (on_t[c] == 0) begin
        n = 0;
        repeat (600) begin
          @(posedge clk);
          n += (row_on !== 8'h00);
        end
        chk(n, 0);
      end else begin
        lit_len(n, r0);
        lit_len(n, r);
        chk(n, on_t[c] * DIV);
        chk(r, (r0 + 1) % 8);
      end
      chk(peak_sel, c & 3);
    end
    // Frame length; row 0 lights one clock after the frame pulse
    do @(posedge clk); while (frame_start !== 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 1) chk(row_on, 8'h01);
    end while (frame_start !== 1'b1);
    chk(n, 512 * DIV);
    // External source, direct then divided; switched in the dark gap
    lit_len(n, r);
    wr(8'h08, 32'h1);
    lit_len(n, r);
    chk_near(n, 6000);
    // Serial mode bit is only stored and must not upset the refresh
    wr(8'h04, 32'h3);
    fast <= 1'b1;
    lit_len(n, r);
    chk_near(n, 6000);
    // Asleep: display dark and refresh count frozen
    wr(8'h00, 32'h0F);
    repeat (8) @(posedge clk);
    chk(row_on, 8'h00);
    chk(col_on, 20'h00000);
    rd(8'h0C, d);
    repeat (50) @(posedge clk);
    rd(8'h0C, d2);
    chk(d2, d);
    rd(8'h04, d);
    chk(d, 32'h3);
    rd(8'h08, d);
    chk(d, 32'h1);
    complete_run();
  end
endmodule
